// *** hw/adccal_consts.svh ***
`ifndef ADCCAL_CONSTS_SVH
`define ADCCAL_CONSTS_SVH

// Special-function address and reset value of the calibration register
`define ADCCAL_CTRL_ADDR 8'hF5
`define ADCCAL_CTRL_RESET 8'h00

// Field positions inside the calibration register
`define ADCCAL_BUSY_BIT 7
`define ADCCAL_GAIN_DIS_BIT 6
`define ADCCAL_AVG_HI_BIT 5
`define ADCCAL_AVG_LO_BIT 4
`define ADCCAL_OFS_DIS_BIT 3
`define ADCCAL_MODE_BIT 2
`define ADCCAL_TYPE_BIT 1
`define ADCCAL_START_BIT 0

// Readings averaged per bit decision, by averaging code
`define ADCCAL_AVG_CODE0 6'h0F
`define ADCCAL_AVG_CODE1 6'h1F
`define ADCCAL_AVG_CODE2 6'h2F
`define ADCCAL_AVG_CODE3 6'h3F

// Input selector codes
`define ADCCAL_SEL_LAST_EXT 4'h5
`define ADCCAL_SEL_TEMP 4'h8
`define ADCCAL_SEL_DAC_FIRST 4'h9
`define ADCCAL_SEL_DAC_SECOND 4'hA
`define ADCCAL_SEL_AGND 4'hB
`define ADCCAL_SEL_VREF 4'hC

`endif

// *** hw/adccal_pkg.sv ***
`default_nettype none
package adccal_pkg;

  // Calibration control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic busy;
    logic gain_correction_disable;
    logic average_count_sel_hi;
    logic average_count_sel_lo;
    logic offset_correction_disable;
    logic calibration_mode_sel;
    logic calibration_type_sel;
    logic calibration_start;
  } adccal_ctrl_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ADCCAL_IDLE,
    ADCCAL_CONV,
    ADCCAL_ISSUE,
    ADCCAL_WAIT
  } adccal_state_t;

endpackage : adccal_pkg
`default_nettype wire

// *** hw/adccal_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adccal_consts.svh"

module adccal_ctrl #(
  parameter int ADC_BITS = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_q,
  // Conversion request and input selector
  input wire logic conv_req,
  input wire logic [3:0] chan_sel,
  // Successive-approximation engine
  output logic sar_start_q,
  input wire logic sar_done,
  // Analog input routing
  output logic [3:0] mux_sel_q,
  output logic mux_en_q,
  // Calibration and correction controls
  output logic cal_run_q,
  output logic cal_gain_q,
  output logic gain_corr_en_q,
  output logic offset_corr_en_q
);

  localparam int BW = (ADC_BITS > 1) ? $clog2(ADC_BITS) : 1;
  localparam logic [BW-1:0] LAST_BIT = BW'(ADC_BITS - 1);

  // Counters below are sized for the range the logic can serve
  if (ADC_BITS < 2 || ADC_BITS > 16) begin : g_bad_bits
    $error("ADC_BITS must lie in 2..16");
  end

  // Whether a selector code connects a source
  function automatic logic sel_valid(input logic [3:0] code);
    sel_valid = (code <= `ADCCAL_SEL_LAST_EXT) ||
                (code >= `ADCCAL_SEL_TEMP && code <= `ADCCAL_SEL_VREF);
  endfunction : sel_valid

  // Readings per bit decision for an averaging code
  function automatic logic [5:0] avg_count(input logic [1:0] code);
    case (code)
      2'h0: avg_count = `ADCCAL_AVG_CODE0;
      2'h1: avg_count = `ADCCAL_AVG_CODE1;
      2'h2: avg_count = `ADCCAL_AVG_CODE2;
      default: avg_count = `ADCCAL_AVG_CODE3;
    endcase
  endfunction : avg_count

  adccal_pkg::adccal_ctrl_t ctrl_q, ctrl_d;
  adccal_pkg::adccal_state_t state_q, state_d;
  logic [5:0] rd_cnt_q, rd_cnt_d;
  logic [5:0] avg_q, avg_d;
  logic [BW-1:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] sfr_rdata_d;
  logic sar_start_d, mux_en_d, cal_run_d, cal_gain_d;
  logic gain_corr_en_d, offset_corr_en_d;
  logic [3:0] mux_sel_d;
  logic hit, wr_hit, start_wr, cal_last;

  assign hit = (sfr_addr == `ADCCAL_CTRL_ADDR);
  assign wr_hit = sfr_wr && hit;
  assign start_wr = wr_hit && sfr_wdata[`ADCCAL_START_BIT];
  assign cal_last = (rd_cnt_q == avg_q - 6'h01) && (bit_cnt_q == LAST_BIT);

  // Next-state logic for register, sequencer and outputs
  always_comb begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    rd_cnt_d = rd_cnt_q;
    bit_cnt_d = bit_cnt_q;
    avg_d = avg_q;
    sar_start_d = 1'b0;
    mux_sel_d = mux_sel_q;
    mux_en_d = mux_en_q;
    cal_run_d = cal_run_q;
    cal_gain_d = cal_gain_q;
    sfr_rdata_d = 8'h00;
    // busy read only: software writes skip bit 7
    if (wr_hit) begin
      ctrl_d[6:1] = sfr_wdata[6:1];
      // start on write: a zero cannot abort a running cycle
      ctrl_d.calibration_start = sfr_wdata[`ADCCAL_START_BIT] ||
                                 ctrl_q.calibration_start;
    end
    case (state_q)
      adccal_pkg::ADCCAL_IDLE: begin
        // launch calibration with the settings held now
        if (ctrl_q.calibration_start) begin
          state_d = adccal_pkg::ADCCAL_ISSUE;
          ctrl_d.busy = 1'b1;
          rd_cnt_d = 6'h00;
          bit_cnt_d = '0;
          avg_d = avg_count({ctrl_q.average_count_sel_hi,
                             ctrl_q.average_count_sel_lo});
          cal_run_d = 1'b1;
          // calibration type picks ground or reference
          cal_gain_d = ctrl_q.calibration_type_sel;
          mux_sel_d = ctrl_q.calibration_type_sel ? `ADCCAL_SEL_VREF :
                                                    `ADCCAL_SEL_AGND;
          mux_en_d = 1'b1;
        // invalid codes start nothing and connect nothing
        end else if (conv_req && sel_valid(chan_sel)) begin
          // route the selected source for conversion
          state_d = adccal_pkg::ADCCAL_CONV;
          ctrl_d.busy = 1'b1;
          mux_sel_d = chan_sel;
          mux_en_d = 1'b1;
          sar_start_d = 1'b1;
        end
      end
      adccal_pkg::ADCCAL_CONV: begin
        if (sar_done) begin
          state_d = adccal_pkg::ADCCAL_IDLE;
          ctrl_d.busy = 1'b0;
          mux_en_d = 1'b0;
        end
      end
      adccal_pkg::ADCCAL_ISSUE: begin
        sar_start_d = 1'b1;
        state_d = adccal_pkg::ADCCAL_WAIT;
      end
      adccal_pkg::ADCCAL_WAIT: begin
        if (sar_done) begin
          state_d = adccal_pkg::ADCCAL_ISSUE;
          if (rd_cnt_q == avg_q - 6'h01) begin
            rd_cnt_d = 6'h00;
            bit_cnt_d = bit_cnt_q + BW'(1);
          end else begin
            rd_cnt_d = rd_cnt_q + 6'h01;
          end
          if (cal_last) begin
            state_d = adccal_pkg::ADCCAL_IDLE;
            ctrl_d.busy = 1'b0;
            cal_run_d = 1'b0;
            mux_en_d = 1'b0;
            // start self-clears; a fresh write of one wins
            ctrl_d.calibration_start = start_wr;
          end
        end
      end
      default: begin
        state_d = adccal_pkg::ADCCAL_IDLE;
      end
    endcase
    // correction enables follow the disable bits
    gain_corr_en_d = !ctrl_d.gain_correction_disable;
    offset_corr_en_d = !ctrl_d.offset_correction_disable;
    // Read data answers one cycle later; unmapped reads give zero
    if (sfr_rd && hit) begin
      sfr_rdata_d = ctrl_q;
    end
  end

  // register and outputs reset to zero, except the two correction enables, which reset to one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ADCCAL_CTRL_RESET;
      state_q <= adccal_pkg::ADCCAL_IDLE;
      rd_cnt_q <= 6'h00;
      bit_cnt_q <= '0;
      avg_q <= `ADCCAL_AVG_CODE0;
      sfr_rdata_q <= 8'h00;
      sar_start_q <= 1'b0;
      mux_sel_q <= 4'h0;
      mux_en_q <= 1'b0;
      cal_run_q <= 1'b0;
      cal_gain_q <= 1'b0;
      gain_corr_en_q <= 1'b1;
      offset_corr_en_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      rd_cnt_q <= rd_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      avg_q <= avg_d;
      sfr_rdata_q <= sfr_rdata_d;
      sar_start_q <= sar_start_d;
      mux_sel_q <= mux_sel_d;
      mux_en_q <= mux_en_d;
      cal_run_q <= cal_run_d;
      cal_gain_q <= cal_gain_d;
      gain_corr_en_q <= gain_corr_en_d;
      offset_corr_en_q <= offset_corr_en_d;
    end
  end

  // Checks on the sequencer and register behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  invalid_sel_idle_a: assert property (
    (state_q == adccal_pkg::ADCCAL_IDLE && !ctrl_q.calibration_start &&
     conv_req && !sel_valid(chan_sel)) |=>
    (!mux_en_q && !sar_start_q && !ctrl_q.busy))
    else $error("invalid selector started a conversion");
  conv_route_a: assert property (
    (state_q == adccal_pkg::ADCCAL_IDLE && !ctrl_q.calibration_start &&
     conv_req && sel_valid(chan_sel)) |=>
    (sar_start_q && mux_en_q && mux_sel_q == $past(chan_sel)))
    else $error("conversion did not route the selected input");
  busy_idle_a: assert property (
    (state_q == adccal_pkg::ADCCAL_IDLE && !ctrl_q.calibration_start &&
     !conv_req) |=> !ctrl_q.busy)
    else $error("busy set without a cycle");
  busy_end_a: assert property (
    (state_q == adccal_pkg::ADCCAL_CONV && sar_done) |=>
    (!ctrl_q.busy && state_q == adccal_pkg::ADCCAL_IDLE))
    else $error("busy not cleared after conversion");
  corr_en_a: assert property (
    gain_corr_en_q == !ctrl_q.gain_correction_disable &&
    offset_corr_en_q == !ctrl_q.offset_correction_disable)
    else $error("correction enable disagrees with register");
  avg_bound_a: assert property (
    cal_run_q |-> (rd_cnt_q < avg_q && avg_q[3:0] == 4'hF))
    else $error("reading counter out of range");
  cal_source_a: assert property (
    cal_run_q |-> mux_sel_q == (cal_gain_q ? `ADCCAL_SEL_VREF :
                                             `ADCCAL_SEL_AGND))
    else $error("calibration routed the wrong source");
  cal_launch_a: assert property (
    (state_q == adccal_pkg::ADCCAL_IDLE && ctrl_q.calibration_start) |=>
    (cal_run_q && ctrl_q.busy) ##1 sar_start_q)
    else $error("calibration did not launch");
  start_clear_a: assert property (
    (state_q == adccal_pkg::ADCCAL_WAIT && sar_done && cal_last &&
     !start_wr) |=> (!ctrl_q.calibration_start && !cal_run_q))
    else $error("start bit not cleared at calibration end");
  sfr_read_a: assert property (
    (sfr_rd && hit) |=> sfr_rdata_q == $past(ctrl_q))
    else $error("register read returned wrong value");

  conv_done_c: cover property (
    state_q == adccal_pkg::ADCCAL_CONV && sar_done);
  cal_done_c: cover property (
    state_q == adccal_pkg::ADCCAL_WAIT && sar_done && cal_last);
  invalid_req_c: cover property (
    state_q == adccal_pkg::ADCCAL_IDLE && conv_req && !sel_valid(chan_sel));

endmodule : adccal_ctrl
`default_nettype wire

// *** dv/adccal_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adccal_consts.svh"

module testbench;
  // Two bit decisions keep calibration runs short
  localparam int ABITS = 2;
  logic core_clk, rst_n, sfr_wr, sfr_rd, conv_req;
  logic sar_done = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, rd_v, d, a;
  logic [3:0] chan_sel, mux_sel_q;
  logic sar_start_q, mux_en_q, cal_run_q, cal_gain_q;
  logic gain_corr_en_q, offset_corr_en_q;
  logic [1:0] avg;
  logic [31:0] seed = 32'h8D5FFCEC;
  adccal_pkg::adccal_ctrl_t cv;
  int n_fail = 0;
  int n_compared = 0;
  int n_starts = 0;
  int s0;

  adccal_ctrl #(.ADC_BITS(ABITS)) adccal_ctrl_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata_q(sfr_rdata_q), .conv_req(conv_req), .chan_sel(chan_sel),
    .sar_start_q(sar_start_q), .sar_done(sar_done), .mux_sel_q(mux_sel_q),
    .mux_en_q(mux_en_q), .cal_run_q(cal_run_q), .cal_gain_q(cal_gain_q),
    .gain_corr_en_q(gain_corr_en_q), .offset_corr_en_q(offset_corr_en_q));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Readings per bit decision; middle codes are the designer's pick
  function automatic int avg_count(input logic [1:0] c);
    return 15 + 16 * int'(c);
  endfunction : avg_count

  function automatic bit valid_sel(input int c);
    return (c <= 5) || (c >= 8 && c <= 12);
  endfunction : valid_sel

  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_sig(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_sig

  // Inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic reg_write(input logic [7:0] ad, input logic [7:0] v);
    sfr_addr = ad;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ad, output logic [7:0] v);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    tick();
    sfr_rd = 1'b0;
    v = sfr_rdata_q;
  endtask : reg_read

  task automatic conv(input logic [3:0] c);
    chan_sel = c;
    conv_req = 1'b1;
    tick();
    conv_req = 1'b0;
  endtask : conv

  // Bounded wait for the source to be released
  task automatic wait_idle();
    for (int k = 0; k < 2000; k++) begin
      if (mux_en_q === 1'b0) begin
        return;
      end
      tick();
    end
    n_fail++;
    print_verdict();
  endtask : wait_idle

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Engine stand-in: answers each reading after a random delay
  always @(posedge core_clk) begin
    if (sar_start_q === 1'b1) begin
      n_starts++;
      // Reads the seed only, so the stimulus process stays its sole writer
      repeat ((n_starts ^ int'(seed[7:0])) % 3) @(posedge core_clk);
      #1 sar_done = 1'b1;
      @(posedge core_clk);
      #1 sar_done = 1'b0;
    end
  end

  initial begin
    {rst_n, sfr_wr, sfr_rd, conv_req} = 4'h0;
    {sfr_addr, sfr_wdata, chan_sel} = 20'h00000;
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    reg_read(`ADCCAL_CTRL_ADDR, rd_v);
    cmp_reg(rd_v, `ADCCAL_CTRL_RESET);
    cmp_sig({gain_corr_en_q, offset_corr_en_q}, 16'h0003);
    // Field writes, busy bit ignored, other addresses refused
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hFA : (i == 1) ? 8'h80 : 8'(rnd()) & 8'hFA;
      reg_write(`ADCCAL_CTRL_ADDR, d);
      reg_read(`ADCCAL_CTRL_ADDR, rd_v);
      cmp_reg(rd_v, d & 8'h7A);
      cmp_sig({gain_corr_en_q, offset_corr_en_q}, {!d[6], !d[3]});
      a = 8'(rnd());
      a = (a == 8'hF5) ? 8'hF4 : a;
      reg_write(a, 8'h48);
      reg_read(a, rd_v);
      cmp_reg(rd_v, 8'h00);
      // A stray write must leave the register alone
      tick();
      reg_read(`ADCCAL_CTRL_ADDR, rd_v);
      cmp_reg(rd_v, d & 8'h7A);
    end
    reg_write(`ADCCAL_CTRL_ADDR, 8'h00);
    // Every selector code, valid ones convert, invalid ones drop
    for (int c = 0; c < 16; c++) begin
      conv(4'(c));
      if (valid_sel(c)) begin
        cmp_sig({sar_start_q, mux_en_q, mux_sel_q}, {2'b11, 4'(c)});
        reg_read(`ADCCAL_CTRL_ADDR, rd_v);
        cmp_reg(rd_v, 8'h80);
        wait_idle();
        reg_read(`ADCCAL_CTRL_ADDR, rd_v);
        cmp_reg(rd_v, 8'h00);
      end else begin
        cmp_sig({sar_start_q, mux_en_q}, 16'h0000);
        // Let an edge pass so the next request is a fresh pulse
        tick();
      end
    end
    // Both calibration types over boundary and random averaging codes
    for (int j = 0; j < 6; j++) begin
      avg = (j < 2) ? 2'b00 : (j < 4) ? 2'b11 : 2'(rnd());
      cv = '0;
      cv.gain_correction_disable = 1'(rnd());
      {cv.average_count_sel_hi, cv.average_count_sel_lo} = avg;
      cv.calibration_mode_sel = 1'b1;
      cv.calibration_type_sel = 1'(j);
      cv.calibration_start = 1'b1;
      s0 = n_starts;
      reg_write(`ADCCAL_CTRL_ADDR, cv);
      tick();
      cmp_sig({cal_run_q, cal_gain_q, mux_en_q, mux_sel_q},
        {3'b101 | 3'(j % 2) << 1, (j % 2) ? 4'hC : 4'hB});
      conv(4'h3);
      wait_idle();
      cmp_sig(16'(n_starts - s0), 16'(ABITS * avg_count(avg)));
      reg_read(`ADCCAL_CTRL_ADDR, rd_v);
      cmp_reg(rd_v, cv & 8'h7E);
    end
    // Idle reset with both disable bits set brings back the reset value and both enables
    reg_write(`ADCCAL_CTRL_ADDR, 8'h48);
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    reg_read(`ADCCAL_CTRL_ADDR, rd_v);
    cmp_reg(rd_v, `ADCCAL_CTRL_RESET);
    cmp_sig({gain_corr_en_q, offset_corr_en_q}, 16'h0003);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
